/* File: rtl/eau_addr_calc.sv */
// First-level address formation from the mode field and displacement.
`timescale 1ns/1ps
`default_nettype none
`include "eau_regs.svh"
module eau_addr_calc
  import eau_pkg::*;
(
  input wire eau_word_t instr,
  input wire eau_word_t pc,
  input wire eau_word_t base_register_two,
  input wire eau_word_t base_register_three,
  output eau_word_t ea
);
  wire logic [1:0] xmode;
  wire logic [7:0] disp;
  wire eau_word_t disp_ext;
  wire eau_word_t page0_addr;
  wire eau_word_t base_sel;
  wire eau_word_t rel_sum;

  assign xmode = instr[`EAU_IR_X_HI:`EAU_IR_X_LO];
  assign disp = instr[`EAU_IR_D_HI:`EAU_IR_D_LO];
  assign page0_addr = {8'h00, disp}; // RULE2
  assign disp_ext = {{8{disp[`EAU_IR_D_SIGN]}}, disp}; // RULE4
  assign base_sel = (xmode == `EAU_X_REL) ? pc : // RULE3
                    (xmode == `EAU_X_BASE2) ? base_register_two : // RULE5
                    base_register_three;
  // The sum is kept to 16 bits so that it wraps with no overflow trap.
  assign rel_sum = 16'(base_sel + disp_ext); // RULE19
  assign ea = (xmode == `EAU_X_PAGE0) ? page0_addr : rel_sum;
endmodule : eau_addr_calc
`default_nettype wire

/* File: rtl/eau_autoidx.sv */
// Auto-index range detection and the modified pointer word.
`timescale 1ns/1ps
`default_nettype none
`include "eau_regs.svh"
module eau_autoidx
  import eau_pkg::*;
(
  input wire eau_word_t addr,
  input wire eau_word_t word,
  output logic hit,
  output eau_word_t mod_word
);
  wire logic inc_hit;
  wire logic dec_hit;

  assign inc_hit = (addr >= `EAU_AI_INC_LO) && (addr <= `EAU_AI_INC_HI); // RULE12
  assign dec_hit = (addr >= `EAU_AI_DEC_LO) && (addr <= `EAU_AI_DEC_HI); // RULE13
  assign hit = inc_hit || dec_hit; // RULE11
  assign mod_word = inc_hit ? 16'(word + `EAU_ONE) : 16'(word - `EAU_ONE);
endmodule : eau_autoidx
`default_nettype wire

/* File: rtl/eau_pkg.sv */
// Types shared by the effective address unit modules.
`default_nettype none
package eau_pkg;
  typedef logic [15:0] eau_word_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_IND_RD,
    ST_IND_WB,
    ST_OP_RD,
    ST_OP_WR
  } eau_state_t;
endpackage : eau_pkg
`default_nettype wire

/* File: rtl/eau_regs.svh */
// Register offsets, instruction field positions and fixed values of the effective address unit.
`ifndef EAU_REGS_SVH
`define EAU_REGS_SVH

`define EAU_OFF_CTRL 8'h00
`define EAU_OFF_INSTR 8'h04
`define EAU_OFF_PC 8'h08
`define EAU_OFF_ACC0 8'h0C
`define EAU_OFF_ACC1 8'h10
`define EAU_OFF_ACC2 8'h14
`define EAU_OFF_ACC3 8'h18
`define EAU_OFF_STATUS 8'h1C
`define EAU_OFF_EA 8'h20
`define EAU_ACC_STRIDE 8'h04

`define EAU_CTRL_START 0
`define EAU_CTRL_MODE64 1
`define EAU_STAT_BUSY 0
`define EAU_STAT_DONE 1
`define EAU_STAT_ERR 2

`define EAU_IR_CLASS 15
`define EAU_IR_OP_HI 14
`define EAU_IR_OP_LO 13
`define EAU_IR_TGT_HI 12
`define EAU_IR_TGT_LO 11
`define EAU_IR_IND 10
`define EAU_IR_X_HI 9
`define EAU_IR_X_LO 8
`define EAU_IR_D_HI 7
`define EAU_IR_D_LO 0
`define EAU_IR_D_SIGN 7

`define EAU_OP_LOAD 2'h1
`define EAU_OP_STORE 2'h2
`define EAU_X_PAGE0 2'h0
`define EAU_X_REL 2'h1
`define EAU_X_BASE2 2'h2
`define EAU_X_BASE3 2'h3

`define EAU_AI_INC_LO 16'h0010
`define EAU_AI_INC_HI 16'h0017
`define EAU_AI_DEC_LO 16'h0018
`define EAU_AI_DEC_HI 16'h001F
`define EAU_ONE 16'h0001
`define EAU_W_MSB 15

`define EAU_RST_WORD 16'h0000
`define EAU_RESP_OKAY 2'h0
`define EAU_RESP_DECERR 2'h3

`endif

/* File: rtl/eau_top.sv */
// Effective address unit: AXI4-Lite registers, address chase and load/store to memory.
//
// Contract
// RULE1: Decode indirect, mode, displacement fields, bit0 MSB.
// RULE2: Mode 00: unsigned displacement addresses page zero.
// RULE3: Mode 01: program counter plus signed displacement.
// RULE4: Relative displacement is sign-extended eight-bit byte.
// RULE5: Mode 10/11: base register two/three plus displacement.
// RULE6: Indirect flag fetches address word from memory.
// RULE7: Fetched word with clear MSB is final.
// RULE8: 32K mode chases set-MSB words without limit.
// RULE9: 64K mode: one level, whole word used.
// RULE10: 64K mode: MSB selects upper half memory.
// RULE11: Auto-index low range only during indirect steps.
// RULE12: Locations 20-27 octal increment the pointer.
// RULE13: Locations 30-37 octal decrement the pointer.
// RULE14: Modified pointer written back to same location.
// RULE15: Modified value, new MSB, steers the chase.
// RULE16: Opcode 01 loads, 10 stores.
// RULE17: Load copies memory word into selected accumulator.
// RULE18: Store writes selected accumulator, accumulator unchanged.
// RULE19: Address sums wrap modulo sixteen bits.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "eau_regs.svh"
module eau_top
  import eau_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_got_reg, w_got_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  eau_word_t instr_reg, pc_reg, ea_reg, ptr_reg;
  eau_word_t acc_reg [0:3];
  logic mode64_reg, done_reg, err_reg;
  eau_state_t state_reg;
  logic mem_req_reg, mem_we_reg;
  eau_word_t mem_addr_reg, mem_wdata_reg;

  // Byte-lane merge for the 16-bit registers; upper lanes are ignored.
  function automatic eau_word_t merge(input eau_word_t old, input logic [31:0] d,
                                      input logic [3:0] strb);
    merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Known register offsets; anything else answers DECERR.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `EAU_OFF_CTRL) || (a == `EAU_OFF_INSTR) || (a == `EAU_OFF_PC) ||
                (a == `EAU_OFF_ACC0) || (a == `EAU_OFF_ACC1) || (a == `EAU_OFF_ACC2) ||
                (a == `EAU_OFF_ACC3) || (a == `EAU_OFF_STATUS) || (a == `EAU_OFF_EA);
  endfunction : is_mapped

  wire logic busy;
  wire logic wr_fire;
  wire logic ar_fire;
  wire logic start_fire;
  wire logic done_clr;
  wire logic [1:0] op_code;
  wire logic [1:0] target_register_select;
  wire logic ind_flag;
  wire logic legal_op;
  wire logic is_load;
  wire eau_word_t ea_calc;
  wire logic ai_hit;
  wire eau_word_t ai_word;
  wire eau_word_t resolve_word;
  wire logic chase_more;
  wire logic mem_done;
  wire logic [31:0] rd_mux;
  wire eau_word_t status_word;

  assign busy = (state_reg != ST_IDLE);
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign ar_fire = s_arvalid && arready_reg;
  assign start_fire = wr_fire && (awaddr_reg == `EAU_OFF_CTRL) && wstrb_reg[0] &&
                      wdata_reg[`EAU_CTRL_START] && !busy;
  assign done_clr = wr_fire && (awaddr_reg == `EAU_OFF_STATUS) && wstrb_reg[0] &&
                    wdata_reg[`EAU_STAT_DONE];

  assign op_code = instr_reg[`EAU_IR_OP_HI:`EAU_IR_OP_LO]; // RULE1
  assign target_register_select = instr_reg[`EAU_IR_TGT_HI:`EAU_IR_TGT_LO]; // RULE1
  assign ind_flag = instr_reg[`EAU_IR_IND]; // RULE1
  assign legal_op = !instr_reg[`EAU_IR_CLASS] &&
                    ((op_code == `EAU_OP_LOAD) || (op_code == `EAU_OP_STORE)); // RULE16
  assign is_load = (op_code == `EAU_OP_LOAD); // RULE16

  eau_addr_calc u_addr_calc (
    .instr(instr_reg),
    .pc(pc_reg),
    .base_register_two(acc_reg[2]),
    .base_register_three(acc_reg[3]),
    .ea(ea_calc)
  );

  eau_autoidx u_autoidx (
    .addr(ea_reg),
    .word(mem_rdata),
    .hit(ai_hit),
    .mod_word(ai_word)
  );

  assign mem_done = mem_req_reg && mem_ack;
  // After a write-back the modified word, not the old one, decides the next step.
  assign resolve_word = (state_reg == ST_IND_WB) ? ptr_reg : mem_rdata; // RULE15
  // In 64K mode the MSB is an address bit, so the chase always ends here.
  assign chase_more = !mode64_reg && resolve_word[`EAU_W_MSB]; // RULE7 RULE8 RULE9 RULE10

  assign status_word = {13'h0000, err_reg, done_reg, busy};
  assign rd_mux = (s_araddr == `EAU_OFF_CTRL) ? {30'h00000000, mode64_reg, 1'b0} :
                  (s_araddr == `EAU_OFF_INSTR) ? {16'h0000, instr_reg} :
                  (s_araddr == `EAU_OFF_PC) ? {16'h0000, pc_reg} :
                  (s_araddr == `EAU_OFF_ACC0) ? {16'h0000, acc_reg[0]} :
                  (s_araddr == `EAU_OFF_ACC1) ? {16'h0000, acc_reg[1]} :
                  (s_araddr == `EAU_OFF_ACC2) ? {16'h0000, acc_reg[2]} :
                  (s_araddr == `EAU_OFF_ACC3) ? {16'h0000, acc_reg[3]} :
                  (s_araddr == `EAU_OFF_STATUS) ? {16'h0000, status_word} :
                  (s_araddr == `EAU_OFF_EA) ? {16'h0000, ea_reg} : 32'h00000000;

  // Write address and data channels are taken independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `EAU_RESP_OKAY;
    end else begin
      if (s_awvalid && awready_reg) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_awaddr;
        awready_reg <= 1'b0;
      end else if (!aw_got_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (s_wvalid && wready_reg) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
        wready_reg <= 1'b0;
      end else if (!w_got_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(awaddr_reg) ? `EAU_RESP_OKAY : `EAU_RESP_DECERR;
      end else if (bvalid_reg && s_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `EAU_RESP_OKAY;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= is_mapped(s_araddr) ? `EAU_RESP_OKAY : `EAU_RESP_DECERR;
    end else if (rvalid_reg && s_rready) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // Software fields. Writes to them while an instruction runs are dropped so
  // that the sequence sees stable operands; the bus still answers OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= `EAU_RST_WORD;
      pc_reg <= `EAU_RST_WORD;
      mode64_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_fire && !busy) begin
        if (awaddr_reg == `EAU_OFF_INSTR) begin
          instr_reg <= merge(instr_reg, wdata_reg, wstrb_reg);
        end
        if (awaddr_reg == `EAU_OFF_PC) begin
          pc_reg <= merge(pc_reg, wdata_reg, wstrb_reg);
        end
        if ((awaddr_reg == `EAU_OFF_CTRL) && wstrb_reg[0]) begin
          mode64_reg <= wdata_reg[`EAU_CTRL_MODE64];
        end
      end
      // Completion in the same cycle as a clear keeps the flag set.
      // The operand word never steers the chase, so its top bit must not hold off done.
      if (mem_done && (state_reg == ST_OP_RD || state_reg == ST_OP_WR)) begin
        done_reg <= 1'b1;
      end else if (start_fire && !legal_op) begin
        done_reg <= 1'b1;
      end else if (done_clr) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Accumulators: software writes when idle, loads from memory at the end.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_acc
      wire logic [7:0] acc_off;
      assign acc_off = 8'(`EAU_OFF_ACC0 + `EAU_ACC_STRIDE * gi);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          acc_reg[gi] <= `EAU_RST_WORD;
        end else if ((state_reg == ST_OP_RD) && mem_done &&
                     (target_register_select == 2'(gi))) begin
          acc_reg[gi] <= mem_rdata; // RULE17
        end else if (wr_fire && !busy && (awaddr_reg == acc_off)) begin
          acc_reg[gi] <= merge(acc_reg[gi], wdata_reg, wstrb_reg);
        end
      end
    end
  endgenerate

  // Address chase and operand transfer. Each memory request stands until
  // mem_ack; the next one is presented in the cycle after its predecessor is acknowledged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      ea_reg <= `EAU_RST_WORD;
      ptr_reg <= `EAU_RST_WORD;
      err_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= `EAU_RST_WORD;
      mem_wdata_reg <= `EAU_RST_WORD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_fire) begin
            err_reg <= !legal_op;
            ea_reg <= ea_calc;
            if (legal_op && ind_flag) begin
              state_reg <= ST_IND_RD; // RULE6
              mem_req_reg <= 1'b1;
              mem_we_reg <= 1'b0;
              mem_addr_reg <= ea_calc;
            end else if (legal_op) begin
              // Direct addressing never auto-indexes.
              state_reg <= is_load ? ST_OP_RD : ST_OP_WR; // RULE11 RULE16
              mem_req_reg <= 1'b1;
              mem_we_reg <= !is_load;
              mem_addr_reg <= ea_calc;
              mem_wdata_reg <= acc_reg[target_register_select]; // RULE18
            end
          end
        end
        ST_IND_RD, ST_IND_WB: begin
          if (mem_done && (state_reg == ST_IND_RD) && ai_hit) begin
            ptr_reg <= ai_word; // RULE12 RULE13
            state_reg <= ST_IND_WB;
            mem_we_reg <= 1'b1;
            mem_addr_reg <= ea_reg; // RULE14
            mem_wdata_reg <= ai_word; // RULE14
          end else if (mem_done) begin
            ea_reg <= resolve_word; // RULE15
            mem_addr_reg <= resolve_word;
            if (chase_more) begin
              state_reg <= ST_IND_RD; // RULE8
              mem_we_reg <= 1'b0;
            end else begin
              state_reg <= is_load ? ST_OP_RD : ST_OP_WR; // RULE7 RULE9
              mem_we_reg <= !is_load;
              mem_wdata_reg <= acc_reg[target_register_select]; // RULE18
            end
          end
        end
        ST_OP_RD, ST_OP_WR: begin
          if (mem_done) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          mem_req_reg <= 1'b0;
        end
      endcase
    end
  end

  assign s_awready = awready_reg;
  assign s_wready = wready_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rdata = rdata_reg;
  assign s_rresp = rresp_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
endmodule : eau_top
`default_nettype wire

/* File: testbench/eau_mem_model.sv */
// Main memory model that answers each request after a chosen number of wait cycles.
`timescale 1ns/1ps
`default_nettype none
module eau_mem_model (
  input wire logic aclk,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:65535];
  logic [3:0] wait_reg;
  initial begin
    mem_ack = 1'h0;
    mem_rdata = 16'h0000;
    wait_reg = 4'h0;
  end
  // Data toggles outside the acknowledge so a stale word is never taken as an answer.
  always @(posedge aclk) begin
    mem_ack <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && wait_reg == lat) begin
      mem_ack <= 1'h1;
      wait_reg <= 4'h0;
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr];
      end
    end else if (mem_req && !mem_ack) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : eau_mem_model
`default_nettype wire

/* File: testbench/eau_top_checker.sv */
// Checker for the memory port and response channels of the effective address unit.
`timescale 1ns/1ps
`default_nettype none
module eau_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire rd_ack = mem_req && !mem_we && mem_ack;
  wire inc_hit = mem_addr >= 16'h0010 && mem_addr <= 16'h0017;
  wire dec_hit = mem_addr >= 16'h0018 && mem_addr <= 16'h001F;
  // A write-back is recognised by the same address returning as a write right after the read.
  sequence wb_s;
    mem_req && mem_we && mem_addr == $past(mem_addr);
  endsequence
  AST_INC_WB: assert property (rd_ack && inc_hit ##1 wb_s |->
    mem_wdata == $past(mem_rdata) + 16'h0001) else $error("Increment write-back wrong");
  AST_DEC_WB: assert property (rd_ack && dec_hit ##1 wb_s |->
    mem_wdata == $past(mem_rdata) - 16'h0001) else $error("Decrement write-back wrong");
  AST_WB_SAME: assert property (rd_ack && (inc_hit || dec_hit) ##1 mem_req |->
    mem_we && mem_addr == $past(mem_addr)) else $error("Write-back missing or misplaced");
  AST_WB_STEERS: assert property (mem_req && mem_we && mem_ack ##1 mem_req |->
    ((mem_addr ^ $past(mem_wdata)) & 16'h7FFF) == 16'h0000) else $error("Next address wrong");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("Memory request changed before acknowledge");
  AST_B_DONE: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("Write response repeated");
  AST_R_DONE: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("Read response repeated");
  AST_R_HIGH: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
    else $error("Upper read data not zero");
  AST_RST_QUIET: assert property (disable iff (1'b0) !aresetn |=> !mem_req && !s_bvalid)
    else $error("Activity during reset");
  cover property (rd_ack && inc_hit);
  cover property (rd_ack && dec_hit);
  cover property (mem_req && mem_we && mem_ack && !(inc_hit || dec_hit));
endmodule : eau_top_checker

bind eau_top eau_top_checker eau_top_checker_i (.aclk, .aresetn, .s_bvalid, .s_bready,
  .s_rdata, .s_rvalid, .s_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .mem_rdata);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench: register access over AXI4-Lite and load/store runs against the memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, mem_req, mem_we, mem_ack;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb, lat;
  logic [1:0] s_bresp, s_rresp;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [1:0] op_ld = 2'h1;
  localparam logic [1:0] op_st = 2'h2;

  eau_top eau_top_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);
  eau_mem_model mem_i (.aclk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {s_awaddr, s_wdata} <= {a, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    s_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_bresp});
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid);
    s_rready <= 1'h0;
    d = s_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_rresp});
  endtask : axr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    axr(a, rd, 2'h0);
    chk(nm, {16'h0000, e}, rd);
  endtask : rchk

  task automatic mw(input logic [15:0] a, input logic [15:0] d);
    mem_i.mem[a] = d;
  endtask : mw

  function automatic logic [31:0] mr(input logic [15:0] a);
    return {16'h0000, mem_i.mem[a]};
  endfunction : mr

  function automatic logic [15:0] ins(input logic [1:0] op, tgt, input logic i,
                                      input logic [1:0] x, input logic [7:0] d);
    return {1'h0, op, tgt, i, x, d};
  endfunction : ins

  // Loads the instruction and counter, starts, waits for done and clears it again.
  task automatic run(input logic [15:0] w, input logic [15:0] pc, input logic m64);
    int n;
    axw(8'h04, {16'h0000, w}, 2'h0);
    axw(8'h08, {16'h0000, pc}, 2'h0);
    axw(8'h00, {30'h0, m64, 1'h1}, 2'h0);
    n = 0;
    do begin
      axr(8'h1C, rd, 2'h0);
      n++;
    end while (rd[1] !== 1'h1 && n < 100);
    chk("done", 32'h2, rd & 32'h2);
    axw(8'h1C, 32'h0000_0002, 2'h0);
  endtask : run

  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    aresetn = 1'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata, lat} = 52'h0;
    s_wstrb = 4'h3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    mw(16'h00FF, 16'h1234);
    run(ins(op_ld, 2'h0, 1'h0, 2'h0, 8'hFF), 16'h0000, 1'h0);
    rchk("ea", 8'h20, 16'h00FF);
    rchk("acc0", 8'h0C, 16'h1234);
    chk("mem", 32'h1234, mr(16'h00FF));
    lat <= 4'h3;
    mw(16'hFF85, 16'hBEEF);
    run(ins(op_ld, 2'h1, 1'h0, 2'h1, 8'h80), 16'h0005, 1'h0);
    rchk("ea", 8'h20, 16'hFF85);
    rchk("acc1", 8'h10, 16'hBEEF);
    axw(8'h14, 32'h0000_1000, 2'h0);
    mw(16'h107F, 16'h0A0A);
    run(ins(op_ld, 2'h0, 1'h0, 2'h2, 8'h7F), 16'h0000, 1'h0);
    rchk("ea", 8'h20, 16'h107F);
    rchk("acc0", 8'h0C, 16'h0A0A);
    axw(8'h18, 32'h0000_2000, 2'h0);
    mw(16'h1F81, 16'h0000);
    run(ins(op_st, 2'h1, 1'h0, 2'h3, 8'h81), 16'h0000, 1'h0);
    rchk("ea", 8'h20, 16'h1F81);
    chk("mem", 32'hBEEF, mr(16'h1F81));
    rchk("acc1", 8'h10, 16'hBEEF);
    lat <= 4'h1;
    mw(16'h0040, 16'h8041);
    mw(16'h0041, 16'h8042);
    mw(16'h8041, 16'h8042);
    mw(16'h0042, 16'h0300);
    mw(16'h8042, 16'h0300);
    mw(16'h0300, 16'h5555);
    run(ins(op_ld, 2'h2, 1'h1, 2'h0, 8'h40), 16'h0000, 1'h0);
    rchk("ea", 8'h20, 16'h0300);
    rchk("acc2", 8'h14, 16'h5555);
    mw(16'h0041, 16'h0777);
    run(ins(op_ld, 2'h0, 1'h1, 2'h0, 8'h40), 16'h0000, 1'h1);
    rchk("ea", 8'h20, 16'h8041);
    rchk("acc0", 8'h0C, 16'h8042);
    lat <= 4'h5;
    mw(16'h0010, 16'h0100);
    mw(16'h0101, 16'h4321);
    run(ins(op_ld, 2'h3, 1'h1, 2'h0, 8'h10), 16'h0000, 1'h0);
    chk("mem", 32'h0101, mr(16'h0010));
    rchk("ea", 8'h20, 16'h0101);
    rchk("acc3", 8'h18, 16'h4321);
    lat <= 4'h0;
    mw(16'h001F, 16'h8000);
    mw(16'h7FFF, 16'h0042);
    run(ins(op_ld, 2'h1, 1'h1, 2'h0, 8'h1F), 16'h0000, 1'h0);
    chk("mem", 32'h7FFF, mr(16'h001F));
    rchk("ea", 8'h20, 16'h7FFF);
    rchk("acc1", 8'h10, 16'h0042);
    mw(16'h0018, 16'h0200);
    run(ins(op_st, 2'h2, 1'h1, 2'h0, 8'h18), 16'h0000, 1'h1);
    chk("mem", 32'h01FF, mr(16'h0018));
    chk("mem", 32'h5555, mr(16'h01FF));
    mw(16'h0012, 16'h0055);
    run(ins(op_ld, 2'h0, 1'h0, 2'h0, 8'h12), 16'h0000, 1'h0);
    chk("mem", 32'h0055, mr(16'h0012));
    rchk("acc0", 8'h0C, 16'h0055);
    run(ins(2'h3, 2'h0, 1'h0, 2'h0, 8'h12), 16'h0000, 1'h0);
    rchk("status", 8'h1C, 16'h0004);
    rchk("acc0", 8'h0C, 16'h0055);
    run(16'h8000 | ins(op_ld, 2'h0, 1'h0, 2'h0, 8'hFF), 16'h0000, 1'h0);
    rchk("status", 8'h1C, 16'h0004);
    rchk("acc0", 8'h0C, 16'h0055);
    axw(8'h40, 32'h0000_0000, 2'h3);
    axr(8'h40, rd, 2'h3);
    chk("rdata", 32'h0, rd);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
